// file: hw/gpio_bank_pkg.sv
// constants and types of the programmable port bank
package gpio_bank_pkg;

	localparam int NUM_PORTS = 9;
	localparam int PORT_W    = 8;

	typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_bus_t;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_DATA_BASE = 6'h00;
	localparam logic [5:0] IDX_DIR_BASE  = 6'h01;
	localparam logic [5:0] IDX_STRIDE    = 6'h02;
	localparam logic [5:0] IDX_EIGHT_DATA = 6'h10;
	localparam logic [5:0] IDX_EIGHT_DIR  = 6'h11;
	localparam logic [5:0] IDX_CTL_TWO    = 6'h2F;
	localparam logic [5:0] IDX_DRIVE     = 6'h30;

	// fields of pin_control_reg_two
	localparam int CTL_TTL_BIT   = 0;
	localparam int CTL_IRQSW_BIT = 4;
	localparam int CTL_ALT_BIT   = 5;

	// reset values
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET   = 8'h00;
	localparam logic [7:0] CTL_RESET   = 8'h00;
	localparam logic [8:0] DRIVE_RESET = 9'h000;

	// output stage structure per port
	localparam logic [8:0] DUAL_MASK    = 9'h032;
	localparam logic [8:0] PURE_OD_MASK = 9'h080;

	// alternate read mapping
	localparam int         ALT_LO_PORT = 4;
	localparam int         ALT_HI_PORT = 7;
	localparam logic [7:0] ALT_LO_PIN  = 8'h7C;
	localparam logic [7:0] ALT_HI_PIN  = 8'h3F;

	// shared pin functions
	localparam int WAKE_PORT   = 3;
	localparam int IRQ_G0_PORT = 5;
	localparam int IRQ_G0_LSB  = 1;
	localparam int IRQ_G1_PORT = 7;
	localparam int IRQ_G1_LSB  = 3;
	localparam int IRQ_N       = 3;

	// bus codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef struct packed {
		logic [5:0] idx;
		logic       wr;
		logic       hit;
	} bus_req_t;

endpackage

// file: hw/gpio_port_bank.sv
// port bank with direction, latch, alternate read and drive options
`timescale 1ns/1ns

module gpio_port_bank (
	input  wire  logic                      REF_CLK,
	input  wire  logic                      RESET,
	input  wire  logic                      HSEL,
	input  wire  logic [31:0]               HADDR,
	input  wire  logic [1:0]                HTRANS,
	input  wire  logic                      HWRITE,
	input  wire  logic [2:0]                HSIZE,
	input  wire  logic [31:0]               HWDATA,
	input  wire  logic                      HREADY,
	output var   logic [31:0]               HRDATA,
	output var   logic                      HREADYOUT,
	output var   logic                      HRESP,
	input  wire  gpio_bank_pkg::port_bus_t  PORT_IN,
	output var   gpio_bank_pkg::port_bus_t  PORT_OUT,
	output var   gpio_bank_pkg::port_bus_t  PORT_OE,
	output var   logic                      SEV_TTL_SEL,
	output var   logic [2:0]                EXT_IRQ,
	output var   logic [7:0]                KEY_WAKE
);

	gpio_bank_pkg::port_bus_t  pin_s1_q;
	gpio_bank_pkg::port_bus_t  pin_q;

	gpio_bank_pkg::port_bus_t  lat_q;
	gpio_bank_pkg::port_bus_t  lat_d;
	gpio_bank_pkg::port_bus_t  dir_q;
	gpio_bank_pkg::port_bus_t  dir_d;
	logic [7:0]                ctl_q;
	logic [7:0]                ctl_d;
	logic [8:0]                drv_q;
	logic [8:0]                drv_d;

	gpio_bank_pkg::bus_req_t   dph_q;
	gpio_bank_pkg::bus_req_t   dph_d;
	logic [31:0]               rdata_q;
	logic [31:0]               rdata_d;
	logic                      ready_q;
	logic [5:0]                aidx;
	logic                      take;
	logic                      hit;
	logic [7:0]                rval;

	gpio_bank_pkg::port_bus_t  out_q;
	gpio_bank_pkg::port_bus_t  out_d;
	gpio_bank_pkg::port_bus_t  oe_q;
	gpio_bank_pkg::port_bus_t  oe_d;
	logic                      ttl_q;
	logic [2:0]                irq_q;
	logic [2:0]                irq_d;
	logic [7:0]                wake_q;
	logic [7:0]                wake_d;

	// pins come from the board: two stages before use
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			pin_s1_q <= '0;
			pin_q    <= '0;
		end else begin
			pin_s1_q <= PORT_IN;
			pin_q    <= pin_s1_q;
		end
	end

	// register file, written in the data phase
	always_comb begin
		lat_d = lat_q;
		dir_d = dir_q;
		ctl_d = ctl_q;
		drv_d = drv_q;
		if (dph_q.wr && dph_q.hit) begin
			for (int p = 0; p < gpio_bank_pkg::NUM_PORTS; p++) begin
				if (dph_q.idx == 6'(gpio_bank_pkg::IDX_DATA_BASE
					+ gpio_bank_pkg::IDX_STRIDE * p)) begin
					lat_d[p] = HWDATA[7:0];
				end
				if (dph_q.idx == 6'(gpio_bank_pkg::IDX_DIR_BASE
					+ gpio_bank_pkg::IDX_STRIDE * p)) begin
					dir_d[p] = HWDATA[7:0];
				end
			end
			if (dph_q.idx == gpio_bank_pkg::IDX_CTL_TWO) begin
				ctl_d = HWDATA[7:0];
			end
			if (dph_q.idx == gpio_bank_pkg::IDX_DRIVE) begin
				drv_d = HWDATA[8:0];
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			for (int p = 0; p < gpio_bank_pkg::NUM_PORTS; p++) begin
				lat_q[p] <= gpio_bank_pkg::LATCH_RESET;
				dir_q[p] <= gpio_bank_pkg::DIR_RESET;
			end
			ctl_q <= gpio_bank_pkg::CTL_RESET;
			drv_q <= gpio_bank_pkg::DRIVE_RESET;
		end else begin
			lat_q <= lat_d;
			dir_q <= dir_d;
			ctl_q <= ctl_d;
			drv_q <= drv_d;
		end
	end

	// bus slave: zero wait states, read data taken from next state
	// so a write followed at once by a read returns the new value
	assign aidx = HADDR[7:2];
	assign take = HSEL && HREADY && (HTRANS == gpio_bank_pkg::HTRANS_NONSEQ);
	assign hit  = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0)
		&& ((aidx <= gpio_bank_pkg::IDX_EIGHT_DIR)
		|| (aidx == gpio_bank_pkg::IDX_CTL_TWO)
		|| (aidx == gpio_bank_pkg::IDX_DRIVE));

	always_comb begin
		rval = 8'h00;
		for (int p = 0; p < gpio_bank_pkg::NUM_PORTS; p++) begin
			if (aidx == 6'(gpio_bank_pkg::IDX_DATA_BASE
				+ gpio_bank_pkg::IDX_STRIDE * p)) begin
				rval = (dir_d[p] & lat_d[p]) | (~dir_d[p] & pin_q[p]);
			end
			if (aidx == 6'(gpio_bank_pkg::IDX_DIR_BASE
				+ gpio_bank_pkg::IDX_STRIDE * p)) begin
				rval = dir_d[p];
			end
		end
		if (aidx == gpio_bank_pkg::IDX_CTL_TWO) begin
			rval = ctl_d;
		end
		if (ctl_d[gpio_bank_pkg::CTL_ALT_BIT]) begin
			if (aidx == gpio_bank_pkg::IDX_EIGHT_DATA) begin
				rval = (dir_d[gpio_bank_pkg::ALT_LO_PORT]
					& lat_d[gpio_bank_pkg::ALT_LO_PORT]
					& ~gpio_bank_pkg::ALT_LO_PIN)
					| ((~dir_d[gpio_bank_pkg::ALT_LO_PORT]
					| gpio_bank_pkg::ALT_LO_PIN)
					& pin_q[gpio_bank_pkg::ALT_LO_PORT]);
			end
			if (aidx == gpio_bank_pkg::IDX_EIGHT_DIR) begin
				rval = (dir_d[gpio_bank_pkg::ALT_HI_PORT]
					& lat_d[gpio_bank_pkg::ALT_HI_PORT]
					& ~gpio_bank_pkg::ALT_HI_PIN)
					| ((~dir_d[gpio_bank_pkg::ALT_HI_PORT]
					| gpio_bank_pkg::ALT_HI_PIN)
					& pin_q[gpio_bank_pkg::ALT_HI_PORT]);
			end
		end
	end

	always_comb begin
		dph_d     = '0;
		rdata_d   = rdata_q;
		if (take) begin
			dph_d.idx = aidx;
			dph_d.wr  = HWRITE;
			dph_d.hit = hit;
			if (!HWRITE) begin
				rdata_d = hit ? {24'h000000, rval} : 32'h00000000;
			end
		end
		if (aidx == gpio_bank_pkg::IDX_DRIVE && take && !HWRITE) begin
			rdata_d = {23'h000000, drv_d};
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			dph_q   <= '0;
			rdata_q <= 32'h00000000;
			ready_q <= 1'h1;
		end else begin
			dph_q   <= dph_d;
			rdata_q <= rdata_d;
			ready_q <= 1'h1;
		end
	end

	assign HRDATA    = rdata_q;
	assign HREADYOUT = ready_q;
	assign HRESP     = gpio_bank_pkg::HRESP_OKAY;

	// output stages and shared pin functions
	always_comb begin
		for (int p = 0; p < gpio_bank_pkg::NUM_PORTS; p++) begin
			if (gpio_bank_pkg::PURE_OD_MASK[p]) begin
				out_d[p] = 8'h00;
				oe_d[p]  = dir_q[p] & ~lat_q[p];
			end else if (gpio_bank_pkg::DUAL_MASK[p] && drv_q[p]) begin
				out_d[p] = 8'h00;
				oe_d[p]  = dir_q[p] & ~lat_q[p];
			end else begin
				out_d[p] = lat_q[p];
				oe_d[p]  = dir_q[p];
			end
		end
		if (ctl_q[gpio_bank_pkg::CTL_IRQSW_BIT]) begin
			irq_d = pin_q[gpio_bank_pkg::IRQ_G1_PORT]
				[gpio_bank_pkg::IRQ_G1_LSB +: gpio_bank_pkg::IRQ_N];
		end else begin
			irq_d = pin_q[gpio_bank_pkg::IRQ_G0_PORT]
				[gpio_bank_pkg::IRQ_G0_LSB +: gpio_bank_pkg::IRQ_N];
		end
		// output-direction bits show idle high to the wake-up logic
		wake_d = pin_q[gpio_bank_pkg::WAKE_PORT]
			| dir_q[gpio_bank_pkg::WAKE_PORT];
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			out_q  <= '0;
			oe_q   <= '0;
			ttl_q  <= 1'h0;
			irq_q  <= 3'h0;
			wake_q <= 8'hFF;
		end else begin
			out_q  <= out_d;
			oe_q   <= oe_d;
			ttl_q  <= ctl_q[gpio_bank_pkg::CTL_TTL_BIT];
			irq_q  <= irq_d;
			wake_q <= wake_d;
		end
	end

	assign PORT_OUT   = out_q;
	assign PORT_OE    = oe_q;
	assign SEV_TTL_SEL = ttl_q;
	assign EXT_IRQ    = irq_q;
	assign KEY_WAKE   = wake_q;

endmodule

// file: tb/pin_board.sv
// board model: a pin shows the bank's drive where enabled, else the board
`timescale 1ns/1ns
module pin_board (
	input  wire gpio_bank_pkg::port_bus_t drv,
	input  wire gpio_bank_pkg::port_bus_t oe,
	input  wire gpio_bank_pkg::port_bus_t ext,
	output wire gpio_bank_pkg::port_bus_t pin
);
	assign pin = (oe & drv) | (~oe & ext);
endmodule

// file: tb/gpio_bank_properties.sv
// concurrent checks on the port bank outputs
`timescale 1ns/1ns
module gpio_bank_properties (
	input wire logic                     REF_CLK,
	input wire logic                     RESET,
	input wire logic                     HSEL,
	input wire logic [1:0]               HTRANS,
	input wire logic                     HWRITE,
	input wire logic                     HREADY,
	input wire logic [31:0]              HRDATA,
	input wire gpio_bank_pkg::port_bus_t PORT_IN,
	input wire gpio_bank_pkg::port_bus_t PORT_OUT,
	input wire gpio_bank_pkg::port_bus_t PORT_OE,
	input wire logic                     SEV_TTL_SEL,
	input wire logic [2:0]               EXT_IRQ,
	input wire logic [7:0]               KEY_WAKE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	logic tk;
	logic wr;
	assign tk = HSEL && HREADY && HTRANS == gpio_bank_pkg::HTRANS_NONSEQ;
	assign wr = tk && HWRITE;
	property p_rst; $fell(RESET) |-> PORT_OE == '0 ##1 PORT_OE == '0; endproperty
	a_rst: assert property (p_rst) else $error("drive on after reset");
	property p_sev; PORT_OUT[7] == 8'h00; endproperty
	a_sev: assert property (p_sev) else $error("port seven drives high");
	property p_hrd; !(tk && !HWRITE) |=> $stable(HRDATA); endproperty
	a_hrd: assert property (p_hrd) else $error("read data moved");
	property p_hi; HRDATA[31:9] == '0; endproperty
	a_hi: assert property (p_hi) else $error("read data high bits");
	property p_oe; $changed(PORT_OE) |-> $past(wr, 2) || $past(wr, 3); endproperty
	a_oe: assert property (p_oe) else $error("enable moved alone");
	property p_ttl;
		$changed(SEV_TTL_SEL) |-> $past(wr, 2) || $past(wr, 3);
	endproperty
	a_ttl: assert property (p_ttl) else $error("threshold moved alone");
	property p_wk;
		(PORT_OE[3] == 8'h00)[*4] |-> KEY_WAKE == $past(PORT_IN[3], 3);
	endproperty
	a_wk: assert property (p_wk) else $error("wake levels wrong");
	property p_irq;
		$stable(PORT_IN)[*4] |->
			EXT_IRQ == PORT_IN[5][3:1] || EXT_IRQ == PORT_IN[7][5:3];
	endproperty
	a_irq: assert property (p_irq) else $error("irq group wrong");
endmodule
bind gpio_port_bank gpio_bank_properties gpio_bank_properties_i (
	.REF_CLK(REF_CLK), .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS),
	.HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .PORT_IN(PORT_IN),
	.PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE), .SEV_TTL_SEL(SEV_TTL_SEL),
	.EXT_IRQ(EXT_IRQ), .KEY_WAKE(KEY_WAKE));

// file: tb/tb_top.sv
// self-checking bench of the port bank
`timescale 1ns/1ns
module tb_top;
	logic        REF_CLK = 1'b0;
	logic        RESET = 1'b1;
	logic        HSEL = 1'b0;
	logic        HWRITE = 1'b0;
	logic [1:0]  HTRANS = 2'h0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic        TTL;
	logic [2:0]  IRQ;
	logic [7:0]  WAKE;
	gpio_bank_pkg::port_bus_t pin, pout, poe;
	gpio_bank_pkg::port_bus_t ext = '0;
	int          failures = 0;
	int          n_tests = 0;
	always #5 REF_CLK = ~REF_CLK;
	gpio_port_bank gpio_port_bank_i (.REF_CLK(REF_CLK), .RESET(RESET),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.PORT_IN(pin), .PORT_OUT(pout), .PORT_OE(poe),
		.SEV_TTL_SEL(TTL), .EXT_IRQ(IRQ),
		.KEY_WAKE(WAKE));
	pin_board pin_board_i (.drv(pout), .oe(poe), .ext(ext), .pin(pin));
	task automatic conclude();
		if (failures == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdy();
		int k;
		k = 0;
		do begin
			@(posedge REF_CLK);
			k++;
		end while (HREADYOUT !== 1'b1 && k < 20);
		if (HREADYOUT !== 1'b1) begin
			failures++;
			$display("mismatch at %0t: bus hung", $time);
			conclude();
		end
	endtask
	// one single transfer, entered just after a rising edge
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
			output logic [31:0] r);
		HSEL <= 1'b1;
		HTRANS <= gpio_bank_pkg::HTRANS_NONSEQ;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		rdy();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		rdy();
		r = HRDATA;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, exp);
		chk({31'h0, HRESP}, 32'h0);
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	task automatic t_reset();
		for (int p = 0; p < 9; p++) begin
			chk(poe[p], 32'h0);
			rd(8'(8 * p + 4), 32'h0);
		end
	endtask
	task automatic t_dir();
		ext[0] <= 8'h3C;
		wr(8'h00, 32'hA5);
		tick(4);
		chk(poe[0], 32'h0);
		wr(8'h04, 32'h0F);
		tick(6);
		chk(poe[0], 32'h0F);
		chk(pout[0] & 8'h0F, 32'h05);
		rd(8'h00, 32'h35);
		wr(8'h04, 32'hFF);
		tick(4);
		chk(pout[0], 32'hA5);
	endtask
	task automatic t_alt();
		wr(8'hC0, 32'h010);
		wr(8'h20, 32'hFF);
		wr(8'h24, 32'hFF);
		wr(8'h38, 32'hFF);
		wr(8'h3C, 32'hFF);
		wr(8'h40, 32'h5A);
		wr(8'h44, 32'h3C);
		tick(6);
		chk(poe[4], 32'h00);
		rd(8'h20, 32'hFF);
		rd(8'h40, 32'h18);
		rd(8'h44, 32'h3C);
		wr(8'hBC, 32'h20);
		rd(8'h40, 32'h83);
		rd(8'h44, 32'hC0);
		wr(8'hC0, 32'h000);
		tick(4);
		chk(poe[4], 32'hFF);
	endtask
	task automatic t_p7();
		wr(8'h38, 32'h0F);
		wr(8'hBC, 32'h21);
		tick(4);
		chk(poe[7], 32'hF0);
		chk(TTL, 32'h1);
		rd(8'hBC, 32'h21);
	endtask
	task automatic t_irq();
		ext[5] <= 8'h0E;
		ext[3] <= 8'hA0;
		wr(8'h1C, 32'h0F);
		wr(8'hBC, 32'h20);
		tick(6);
		chk(IRQ, 32'h7);
		chk(WAKE, 32'hAF);
		wr(8'hBC, 32'h30);
		tick(6);
		chk(IRQ, 32'h0);
		wr(8'h80, 32'hFF);
		rd(8'h80, 32'h0);
	endtask
	initial begin
		tick(3);
		RESET <= 1'b0;
		tick(1);
		t_reset();
		t_dir();
		t_alt();
		t_p7();
		t_irq();
		conclude();
	end
endmodule
